// ==== core/pcr_pkg.sv ====
// Constants, field layouts and carriers of the print control register bank.
// Assumes a single 16-bit port bus on the core clock and nothing else.
package pcr_pkg;

  // ----------------------------------------------------------------------
  // Port indices and widths
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;

  localparam logic [4:0] PORT_MODE_STATUS = 5'h01;
  localparam logic [4:0] PORT_MARGIN_LOW  = 5'h02;
  localparam logic [4:0] PORT_PAGE_WIDTH  = 5'h03;
  localparam logic [4:0] PORT_PAGE_HEIGHT = 5'h04;
  localparam logic [4:0] PORT_BAND_LOW    = 5'h05;
  localparam logic [4:0] PORT_RATE_BAND   = 5'h06;
  localparam logic [4:0] PORT_MEM_TIMING  = 5'h07;

  // ----------------------------------------------------------------------
  // Mode and status field positions
  // ----------------------------------------------------------------------
  localparam int unsigned MODE_OP_LSB    = 13;
  localparam int unsigned MODE_POLARITY  = 12;
  localparam int unsigned MODE_REFRESH   = 11;
  localparam int unsigned MODE_IRQ       = 10;
  localparam int unsigned MODE_REPEAT    = 9;
  localparam int unsigned MODE_PRINT     = 8;
  localparam int unsigned STAT_PAGE_DONE = 7;
  localparam int unsigned STAT_OVERRUN   = 6;
  localparam int unsigned STAT_BAND_DISP = 2;
  localparam int unsigned STAT_DISP_DONE = 1;
  localparam int unsigned STAT_DISP_INC  = 0;

  localparam logic [7:0] STAT_IRQ_MASK = 8'hC5;
  localparam logic [7:0] STAT_RESET    = 8'h00;
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [15:0] WORD_RESET   = 16'h0000;

  // ----------------------------------------------------------------------
  // Memory timing field positions
  // ----------------------------------------------------------------------
  localparam int unsigned MT_XMARGIN_HI = 14;
  localparam int unsigned MT_YMARGIN_HI = 12;
  localparam int unsigned MT_FONT_WAIT  = 8;

  typedef enum logic [2:0] {
    OP_SOFT_RESET = 3'b000,
    OP_ROT_READ   = 3'b001,
    OP_ROT_LOAD   = 3'b010,
    OP_DISPATCH   = 3'b011,
    OP_FONT_LOAD  = 3'b100,
    OP_FONT_READ  = 3'b101,
    OP_GFX_LOAD   = 3'b110,
    OP_RESERVED   = 3'b111
  } pcr_op_e;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [4:0]        addr;
    logic [15:0]       wdata;
  } pcr_host_req_s;

  typedef struct packed {
    logic [9:0]  x_margin;
    logic [9:0]  y_margin;
    logic [15:0] page_width;
    logic [15:0] page_height;
    logic [23:0] band_boundary;
    logic [15:0] memory_timing;
  } pcr_config_s;

endpackage : pcr_pkg

// ==== core/pcr_bank.sv ====
// Operation control and status registers of a raster print controller.
// Assumes the host port strobes are on i_core_clk; sync pins are async.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [R1] Mode bits 15:13 select the operation type.
// [R2] Mode/status read clears active status flags.
// [R3] Soft-reset code aborts work, resets band state.
// [R4] Bit 12 sets pixel polarity; idle drives high.
// [R5] Bit 11 enables refresh; clearing stops new cycles.
// [R6] Bit 10 gates interrupt; clearing drops it immediately.
// [R7] Bit 9 selects plain reads for repeat printing.
// [R8] Bit 8 enables printing; syncs gated until loaded.
// [R9] Device clears print enable; host clear aborts.
// [R10] Setting print enable ignored while page done.
// [R11] Status byte write-only clearable by soft reset.
// [R12] Status bit 7 page done, interrupts.
// [R13] Status bit 6 line overrun, interrupts, stops printing.
// [R14] Status bit 2 band reached, interrupts, no dispatch.
// [R15] Status bit 1 dispatch complete raises DMA request.
// [R16] Status bit 0 block crossed band, interrupts.
// [R17] Port 2 holds low margin bytes.
// [R18] Ports 3 and 4 hold page pixel and line counts.
// [R19] Ports 5 and 6 low form band boundary.
// [R20] Port 6 high byte is refresh interval.
// [R21] Memory timing high bits extend margins, no reset.
// [R22] Memory timing bits 10:8 give font wait states.
// [R23] Interrupt while enabled and any interrupting flag pending.
module pcr_bank (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_resetn,
  input  wire pcr_pkg::pcr_host_req_s i_host_req,
  output logic [15:0]                o_host_rdata,
  output logic                       o_host_rvalid,
  input  wire logic                  i_page_sync,
  input  wire logic                  i_line_sync,
  input  wire logic                  i_first_line_loaded,
  input  wire logic                  i_line_busy,
  input  wire logic                  i_page_finished,
  input  wire logic                  i_pixel_black,
  input  wire logic                  i_in_print_area,
  input  wire logic                  i_band_reached,
  input  wire logic                  i_dispatch_complete,
  input  wire logic                  i_band_crossed,
  input  wire logic                  i_band_advance,
  input  wire logic                  i_refresh_ack,
  input  wire logic                  i_font_cycle_start,
  output logic [2:0]                 o_operation,
  output logic                       o_soft_reset,
  output logic                       o_band_select,
  output logic                       o_output_polarity,
  output logic                       o_refresh_enable,
  output logic                       o_refresh_request,
  output logic                       o_repeat_print,
  output logic                       o_print_enable,
  output logic                       o_print_abort,
  output logic                       o_page_sync_ok,
  output logic                       o_line_sync_ok,
  output logic                       o_serial_pixel_out,
  output logic                       o_interrupt_out,
  output logic                       o_dma_request,
  output logic                       o_font_wait,
  output pcr_pkg::pcr_config_s       o_config
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]  mode_reg;
  logic [7:0]  status_reg;
  logic [7:0]  status_next;
  logic [15:0] margin_low_bits_reg;
  logic [15:0] page_width_pixels_reg;
  logic [15:0] page_height_lines_reg;
  logic [15:0] band_boundary_low_reg;
  logic [15:0] refresh_rate_band_high_reg;
  logic [15:0] memory_timing_reg;
  logic [7:0]  refresh_cnt_reg;
  logic [2:0]  font_wait_reg;
  logic        band_reg;
  logic [2:0]  page_sync_reg;
  logic [2:0]  line_sync_reg;
  logic        page_active_reg;

  logic wr_mode;
  logic rd_mode;
  logic soft_reset;
  logic ps_rise;
  logic ls_rise;
  logic ps_accept;
  logic ls_accept;
  logic overrun;
  logic print_set;
  logic print_clr;
  logic host_clear_print;

  assign wr_mode = i_host_req.wr && i_host_req.addr == pcr_pkg::PORT_MODE_STATUS;
  assign rd_mode = i_host_req.rd && i_host_req.addr == pcr_pkg::PORT_MODE_STATUS;
  // [R1] Soft reset decode.
  assign soft_reset = wr_mode && i_host_req.wdata[15:13] ==
                      pcr_pkg::OP_SOFT_RESET;

  // ----------------------------------------------------------------------
  // Sync pin capture
  // ----------------------------------------------------------------------
  // The first stage feeds only the second; edges come from stages 2 and 3.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      page_sync_reg <= 3'h0;
      line_sync_reg <= 3'h0;
    end else begin
      page_sync_reg <= {page_sync_reg[1:0], i_page_sync};
      line_sync_reg <= {line_sync_reg[1:0], i_line_sync};
    end
  end

  assign ps_rise = page_sync_reg[1] && !page_sync_reg[2];
  assign ls_rise = line_sync_reg[1] && !line_sync_reg[2];
  // [R8] Page sync gate.
  assign ps_accept = ps_rise && mode_reg[0] && i_first_line_loaded;
  assign ls_accept = ls_rise && mode_reg[0] && page_active_reg;
  // [R13] Overrun detect.
  assign overrun = ls_accept && i_line_busy;

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      page_active_reg <= 1'b0;
    end else if (!mode_reg[0] || soft_reset) begin
      page_active_reg <= 1'b0;
    end else if (ps_accept) begin
      page_active_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Mode byte
  // ----------------------------------------------------------------------
  // [R10] Set refused on page done.
  assign print_set = wr_mode && i_host_req.wdata[8] &&
                     !status_reg[pcr_pkg::STAT_PAGE_DONE];
  // [R9] Device clears print enable.
  assign print_clr = i_page_finished || overrun;
  assign host_clear_print = wr_mode && !i_host_req.wdata[8] && mode_reg[0];

  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      mode_reg <= pcr_pkg::MODE_RESET;
    end else begin
      if (wr_mode) begin
        // [R1] Operation field store.
        mode_reg[7:5] <= i_host_req.wdata[15:13];
        // [R4] Polarity store.
        mode_reg[4] <= i_host_req.wdata[12];
        // [R5] Refresh enable store.
        mode_reg[3] <= i_host_req.wdata[11];
        // [R6] Interrupt enable store.
        mode_reg[2] <= i_host_req.wdata[10];
        // [R7] Repeat print store.
        mode_reg[1] <= i_host_req.wdata[9];
      end
      if (print_clr) begin
        mode_reg[0] <= 1'b0;
      end else if (wr_mode) begin
        mode_reg[0] <= print_set || (mode_reg[0] && i_host_req.wdata[8]);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status byte
  // ----------------------------------------------------------------------
  // A flag raised in the cycle of a clearing read survives to the next read.
  always_comb begin
    status_next = status_reg;
    // [R2] Clear on read.
    if (rd_mode || soft_reset) begin
      status_next = pcr_pkg::STAT_RESET;
    end
    // [R12] Page done set.
    if (i_page_finished) begin
      status_next[pcr_pkg::STAT_PAGE_DONE] = 1'b1;
    end
    // [R13] Overrun set.
    if (overrun) begin
      status_next[pcr_pkg::STAT_OVERRUN] = 1'b1;
    end
    // [R14] Band reached set.
    if (i_band_reached) begin
      status_next[pcr_pkg::STAT_BAND_DISP] = 1'b1;
    end
    // [R15] Dispatch complete set.
    if (i_dispatch_complete) begin
      status_next[pcr_pkg::STAT_DISP_DONE] = 1'b1;
    end
    // [R16] Band crossed set.
    if (i_band_crossed) begin
      status_next[pcr_pkg::STAT_DISP_INC] = 1'b1;
    end
  end

  // [R11] Writes leave status alone, except a soft-reset write, which clears it.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      status_reg <= pcr_pkg::STAT_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration words
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      margin_low_bits_reg        <= pcr_pkg::WORD_RESET;
      page_width_pixels_reg      <= pcr_pkg::WORD_RESET;
      page_height_lines_reg      <= pcr_pkg::WORD_RESET;
      band_boundary_low_reg      <= pcr_pkg::WORD_RESET;
      refresh_rate_band_high_reg <= pcr_pkg::WORD_RESET;
    end else if (i_host_req.wr) begin
      unique case (i_host_req.addr)
        // [R17] Margin low bytes.
        pcr_pkg::PORT_MARGIN_LOW:  margin_low_bits_reg <= i_host_req.wdata;
        // [R18] Page size counts.
        pcr_pkg::PORT_PAGE_WIDTH:  page_width_pixels_reg <= i_host_req.wdata;
        pcr_pkg::PORT_PAGE_HEIGHT: page_height_lines_reg <= i_host_req.wdata;
        // [R19] Band boundary words.
        pcr_pkg::PORT_BAND_LOW:    band_boundary_low_reg <= i_host_req.wdata;
        pcr_pkg::PORT_RATE_BAND:   refresh_rate_band_high_reg <=
                                   i_host_req.wdata;
        default: ;
      endcase
    end
  end

  // [R21] Memory timing keeps its contents through reset.
  always_ff @(posedge i_core_clk) begin
    if (i_host_req.wr && i_host_req.addr == pcr_pkg::PORT_MEM_TIMING) begin
      memory_timing_reg <= i_host_req.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Band state and refresh timer
  // ----------------------------------------------------------------------
  // [R3] Band back to zero.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn || soft_reset) begin
      band_reg <= 1'b0;
    end else if (i_band_advance) begin
      band_reg <= !band_reg;
    end
  end

  // [R20] Refresh interval count.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn || !mode_reg[3]) begin
      refresh_cnt_reg <= 8'h00;
    end else if (refresh_cnt_reg >= refresh_rate_band_high_reg[15:8]) begin
      refresh_cnt_reg <= 8'h00;
    end else begin
      refresh_cnt_reg <= refresh_cnt_reg + 8'h01;
    end
  end

  // [R5] Pending request dropped on disable.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn || !mode_reg[3]) begin
      o_refresh_request <= 1'b0;
    end else if (refresh_cnt_reg >= refresh_rate_band_high_reg[15:8]) begin
      o_refresh_request <= 1'b1;
    end else if (i_refresh_ack) begin
      o_refresh_request <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Font wait states
  // ----------------------------------------------------------------------
  // [R22] Wait state counter.
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      font_wait_reg <= 3'h0;
    end else if (i_font_cycle_start) begin
      font_wait_reg <= memory_timing_reg[10:8];
    end else if (font_wait_reg != 3'h0) begin
      font_wait_reg <= font_wait_reg - 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Event pulses, pixel output and host read data
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_soft_reset       <= 1'b0;
      o_print_abort      <= 1'b0;
      o_page_sync_ok     <= 1'b0;
      o_line_sync_ok     <= 1'b0;
      o_serial_pixel_out <= 1'b1;
      o_host_rvalid      <= 1'b0;
      o_host_rdata       <= pcr_pkg::WORD_RESET;
    end else begin
      // [R3] Abort pulse.
      o_soft_reset   <= soft_reset;
      // [R9] Host clear aborts page.
      o_print_abort  <= host_clear_print && !print_clr;
      o_page_sync_ok <= ps_accept;
      o_line_sync_ok <= ls_accept;
      // [R4] Polarity and idle high.
      o_serial_pixel_out <= (mode_reg[0] && i_in_print_area) ?
                            (i_pixel_black ^ mode_reg[4]) : 1'b1;
      o_host_rvalid  <= i_host_req.rd;
      unique case (i_host_req.addr)
        pcr_pkg::PORT_MODE_STATUS: o_host_rdata <= {mode_reg, status_reg};
        pcr_pkg::PORT_MARGIN_LOW:  o_host_rdata <= margin_low_bits_reg;
        pcr_pkg::PORT_PAGE_WIDTH:  o_host_rdata <= page_width_pixels_reg;
        pcr_pkg::PORT_PAGE_HEIGHT: o_host_rdata <= page_height_lines_reg;
        pcr_pkg::PORT_BAND_LOW:    o_host_rdata <= band_boundary_low_reg;
        pcr_pkg::PORT_RATE_BAND:   o_host_rdata <= refresh_rate_band_high_reg;
        pcr_pkg::PORT_MEM_TIMING:  o_host_rdata <= memory_timing_reg;
        default:                   o_host_rdata <= pcr_pkg::WORD_RESET;
      endcase
    end
  end

  assign o_operation       = mode_reg[7:5];
  assign o_band_select     = band_reg;
  assign o_output_polarity = mode_reg[4];
  assign o_refresh_enable  = mode_reg[3];
  // [R7] Repeat print selects reads.
  assign o_repeat_print    = mode_reg[1];
  assign o_print_enable    = mode_reg[0];
  // [R6] Interrupt gate.
  assign o_interrupt_out   = mode_reg[2] &&
                             |(status_reg & pcr_pkg::STAT_IRQ_MASK);
  // [R15] DMA request.
  assign o_dma_request     = status_reg[pcr_pkg::STAT_DISP_DONE];
  assign o_font_wait       = font_wait_reg != 3'h0;

  // [R17] Margin assembly.
  assign o_config.x_margin = {memory_timing_reg[15:14],
                              margin_low_bits_reg[15:8]};
  assign o_config.y_margin = {memory_timing_reg[13:12],
                              margin_low_bits_reg[7:0]};
  assign o_config.page_width    = page_width_pixels_reg;
  assign o_config.page_height   = page_height_lines_reg;
  assign o_config.band_boundary = {refresh_rate_band_high_reg[7:0],
                                   band_boundary_low_reg};
  assign o_config.memory_timing = memory_timing_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence page_end_s;
    i_page_finished;
  endsequence

  sequence status_read_s;
    rd_mode && !(|{i_page_finished, overrun, i_band_reached,
                  i_dispatch_complete, i_band_crossed});
  endsequence

  read_clears_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R2]
    status_read_s |=> status_reg == 8'h00)
    else $error("Status not cleared by read.");

  page_done_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R12]
    page_end_s |=> status_reg[7] && !o_print_enable)
    else $error("Page end did not flag or stop printing.");

  overrun_stop_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R13]
    overrun |=> status_reg[6] && !o_print_enable)
    else $error("Overrun did not flag or stop printing.");

  irq_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R6]
    !mode_reg[2] |-> !o_interrupt_out)
    else $error("Interrupt while disabled.");

  irq_source_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R23]
    (mode_reg[2] && status_reg[0]) |-> o_interrupt_out)
    else $error("Pending flag did not interrupt.");

  no_dc_irq_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R15]
    (status_reg == 8'h02) |-> o_dma_request && !o_interrupt_out)
    else $error("Dispatch complete misbehaved.");

  print_refused_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R10]
    (status_reg[7] && !mode_reg[0] && wr_mode) |=> !mode_reg[0])
    else $error("Print enable set while page done.");

  soft_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R11]
    (soft_reset && !(|{i_page_finished, overrun, i_band_reached,
                       i_dispatch_complete, i_band_crossed}))
    |=> status_reg == 8'h00 && !o_band_select && o_soft_reset)
    else $error("Soft reset did not clear state.");

  sync_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R8]
    !mode_reg[0] |=> !o_page_sync_ok && !o_line_sync_ok)
    else $error("Sync accepted while printing disabled.");

  idle_high_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R4]
    !mode_reg[0] |=> o_serial_pixel_out)
    else $error("Pixel output not high while idle.");

  refresh_off_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R5]
    !mode_reg[3] |=> !o_refresh_request)
    else $error("Refresh requested while disabled.");

  font_wait_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R22]
    (i_font_cycle_start && memory_timing_reg[10:8] == 3'h5)
    |=> o_font_wait [*5] ##1 !o_font_wait)
    else $error("Font wait length wrong.");

endmodule : pcr_bank

`default_nettype wire

// ==== verif/pcr_host_model.sv ====
// Host port model: one-cycle read and write strobes on the port bus.
// Assumes read data and its valid pulse follow the strobe within 3 cycles.
`timescale 1ns/1ps
`default_nettype none
module pcr_host_model (
  input  wire logic                 i_core_clk,
  output var  pcr_pkg::pcr_host_req_s o_req,
  input  wire logic [15:0]          i_rdata,
  input  wire logic                 i_rvalid
);
  initial o_req = '0;
  // Strobes move at the falling edge so the bank samples settled values.
  task automatic write(input logic [4:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    o_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge i_core_clk);
    o_req.wr = 1'b0;
  endtask : write
  // The address is held until the data is taken; data is X if none came.
  task automatic read(input logic [4:0] a, output logic [15:0] d);
    int k;
    d = 'x;
    @(negedge i_core_clk);
    o_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~o_req.wdata};
    @(negedge i_core_clk);
    o_req.rd = 1'b0;
    for (k = 0; k < 3; k++) begin
      if (i_rvalid === 1'b1) begin
        d = i_rdata;
        break;
      end
      @(negedge i_core_clk);
    end
  endtask : read
endmodule : pcr_host_model
`default_nettype wire

// ==== verif/pcr_bank_bench.sv ====
// Bench for the print control register bank, one task per scenario.
// Assumes the host model owns the port bus; other inputs are driven here.
`timescale 1ns/1ps
`default_nettype none
module pcr_bank_bench;
  localparam logic [15:0] MD = 16'h6000;
  logic clk, rstn, page_sync, line_sync, loaded, busy, pfin, black, area;
  logic breach, ddone, bcross, badv, rack, fstart;
  logic rvalid, srst, bsel, pol, ren, rreq, rep, pen, abrt, psok, lsok;
  logic pix, irq, dma, fwait;
  logic [15:0] rdata;
  logic [2:0]  op;
  pcr_pkg::pcr_host_req_s req;
  pcr_pkg::pcr_config_s   cfg;
  int n_fail, n_checks, n_cyc, n_sr, n_ab, n_ps, n_ls, k;
  pcr_bank u_dut (.i_core_clk(clk), .i_resetn(rstn), .i_host_req(req),
    .o_host_rdata(rdata), .o_host_rvalid(rvalid), .i_page_sync(page_sync),
    .i_line_sync(line_sync), .i_first_line_loaded(loaded), .i_line_busy(busy),
    .i_page_finished(pfin), .i_pixel_black(black), .i_in_print_area(area),
    .i_band_reached(breach), .i_dispatch_complete(ddone),
    .i_band_crossed(bcross), .i_band_advance(badv), .i_refresh_ack(rack),
    .i_font_cycle_start(fstart), .o_operation(op), .o_soft_reset(srst),
    .o_band_select(bsel), .o_output_polarity(pol), .o_refresh_enable(ren),
    .o_refresh_request(rreq), .o_repeat_print(rep), .o_print_enable(pen),
    .o_print_abort(abrt), .o_page_sync_ok(psok), .o_line_sync_ok(lsok),
    .o_serial_pixel_out(pix), .o_interrupt_out(irq), .o_dma_request(dma),
    .o_font_wait(fwait), .o_config(cfg));
  pcr_host_model u_host (.i_core_clk(clk), .o_req(req), .i_rdata(rdata),
    .i_rvalid(rvalid));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Pulse counters and the hang guard; a run needs far fewer cycles.
  always @(posedge clk) begin
    n_sr += int'(srst === 1'b1);
    n_ab += int'(abrt === 1'b1);
    n_ps += int'(psok === 1'b1);
    n_ls += int'(lsok === 1'b1);
    n_cyc++;
    if (n_cyc == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask : chk
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    u_host.read(a, d);
    chk(d, e);
  endtask : rdc
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    u_host.write(a, d);
  endtask : wr
  task automatic t_reset;
    for (k = 1; k < 7; k++) rdc(k[4:0], 16'h0000);
    rdc(5'h00, 16'h0000);
    chk({pix, irq, ren, bsel, pen}, 5'h10);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    logic [15:0] v [6] = '{16'hA55A, 16'h1234, 16'hFEDC, 16'h8001,
                           16'h3C81, 16'hD500};
    for (k = 0; k < 6; k++) wr(k[4:0] + 5'h02, v[k]);
    for (k = 0; k < 6; k++) rdc(k[4:0] + 5'h02, v[k]);
    wr(5'h09, 16'hFFFF);
    rdc(5'h09, 16'h0000);
    chk({cfg.x_margin, cfg.y_margin}, {10'h3A5, 10'h15A});
    chk(cfg.band_boundary, 24'h818001);
    chk({cfg.page_width, cfg.page_height}, 32'h1234FEDC);
    $display("test registers done");
  endtask : t_regs
  task automatic t_status;
    wr(5'h01, MD | 16'h04FF);
    rdc(5'h01, 16'h6400);
    {pfin, breach, bcross, ddone} = 4'hF;
    @(negedge clk);
    {pfin, breach, bcross, ddone} = 4'h0;
    chk({irq, dma}, 2'b11);
    rdc(5'h01, 16'h6487);
    rdc(5'h01, 16'h6400);
    chk({irq, dma}, 2'b00);
    bcross = 1'b1;
    @(negedge clk);
    bcross = 1'b0;
    chk(irq, 1'b1);
    wr(5'h01, MD);
    chk(irq, 1'b0);
    rdc(5'h01, 16'h6001);
    $display("test status done");
  endtask : t_status
  task automatic t_soft;
    {badv, pfin} = 2'b11;
    @(negedge clk);
    {badv, pfin} = 2'b00;
    chk(bsel, 1'b1);
    wr(5'h01, 16'h0400);
    repeat (2) @(negedge clk);
    chk({n_sr > 0, bsel, irq, op}, 6'h20);
    rdc(5'h01, 16'h0400);
    for (k = 1; k < 7; k++) begin
      wr(5'h01, {k[2:0], 13'h0000});
      chk(op, k[2:0]);
    end
    $display("test soft reset done");
  endtask : t_soft
  task automatic t_guard;
    pfin = 1'b1;
    @(negedge clk);
    pfin = 1'b0;
    wr(5'h01, MD | 16'h0100);
    chk(pen, 1'b0);
    rdc(5'h01, 16'h6080);
    wr(5'h01, MD | 16'h0300);
    chk({pen, rep}, 2'b11);
    k = n_ab;
    wr(5'h01, MD);
    @(negedge clk);
    chk({pen, n_ab - k == 1}, 2'b01);
    {area, black} = 2'b11;
    wr(5'h01, MD | 16'h0100);
    @(negedge clk);
    chk(pix, 1'b1);
    wr(5'h01, MD | 16'h1100);
    @(negedge clk);
    chk({pol, pix}, 2'b10);
    area = 1'b0;
    repeat (2) @(negedge clk);
    chk(pix, 1'b1);
    $display("test print guard done");
  endtask : t_guard
  task automatic t_sync;
    wr(5'h01, MD);
    {loaded, page_sync} = 2'b11;
    repeat (8) @(negedge clk);
    chk(n_ps, 0);
    page_sync = 1'b0;
    wr(5'h01, MD | 16'h0500);
    page_sync = 1'b1;
    repeat (8) @(negedge clk);
    chk(n_ps, 1);
    {busy, line_sync} = 2'b11;
    repeat (8) @(negedge clk);
    chk({n_ls == 1, pen, irq}, 3'b101);
    rdc(5'h01, 16'h6440);
    {loaded, page_sync, busy, line_sync} = 4'h0;
    $display("test sync done");
  endtask : t_sync
  task automatic t_refresh;
    wr(5'h06, 16'h0381);
    wr(5'h01, MD | 16'h0800);
    for (k = 0; k < 20 && rreq !== 1'b1; k++) @(negedge clk);
    rack = 1'b1;
    @(negedge clk);
    rack = 1'b0;
    for (k = 1; k < 20 && rreq !== 1'b1; k++) @(negedge clk);
    chk(k inside {[3:5]}, 1'b1);
    wr(5'h01, MD);
    repeat (12) @(negedge clk);
    chk({ren, rreq}, 2'b00);
    fstart = 1'b1;
    @(negedge clk);
    fstart = 1'b0;
    n_cyc = n_cyc;
    for (k = 0; k < 12; k++) begin
      n_ps += int'(fwait === 1'b1);
      @(negedge clk);
    end
    chk(n_ps, 6);
    $display("test refresh and font wait done");
  endtask : t_refresh
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    {page_sync, line_sync, loaded, busy, pfin, black, area} = '0;
    {breach, ddone, bcross, badv, rack, fstart} = '0;
    rstn = 1'b0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    t_reset();
    t_regs();
    t_status();
    t_soft();
    t_guard();
    t_sync();
    t_refresh();
    complete_run();
  end
endmodule : pcr_bank_bench
`default_nettype wire
